/* see_regs.svh */
// Constants of the serial EEPROM core: opcodes, status layout, timing
`ifndef SEE_REGS_SVH
`define SEE_REGS_SVH
`define SEE_OP_SET_WL 8'h06
`define SEE_OP_CLR_WL 8'h04
`define SEE_OP_STAT_RD 8'h05
`define SEE_OP_STAT_WR 8'h01
`define SEE_OP_MEM_RD 3'h3
`define SEE_OP_MEM_WR 3'h2
`define SEE_ST_BUSY 0
`define SEE_ST_WL 1
`define SEE_ST_BP_LO 2
`define SEE_ST_BP_HI 3
`define SEE_ST_ONES 4'hF
`define SEE_OP_A8_BIT 3
`define SEE_PAGE_BYTES 16
`define SEE_PROG_TIME_US 5000
`define SEE_CLK_MHZ 250
`define SEE_PROG_CYCLES (`SEE_PROG_TIME_US * `SEE_CLK_MHZ)
`endif

/* see_pkg.sv */
// Types shared by the serial EEPROM core
package see_pkg;
  typedef enum logic [4:0] {
    SEE_PH_OPC  = 5'b0_0001,
    SEE_PH_ADR  = 5'b0_0010,
    SEE_PH_DATA = 5'b0_0100,
    SEE_PH_STAT = 5'b0_1000,
    SEE_PH_IDLE = 5'b1_0000
  } see_phase_t;
  typedef struct packed {
    logic [8:0] addr;
    logic [7:0] data;
  } see_wbyte_t;
endpackage

/* see_core.sv */
// Serial EEPROM core: SPI link logic on the serial clock, programming timer on the system clock
`timescale 1ns/10ps
`include "see_regs.svh"

module see_core
  import see_pkg::*;
#(
  parameter int ADDR_W = 9,
  parameter int unsigned PROG_CYCLES = `SEE_PROG_CYCLES
) (
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  input wire logic spi_clk_i,
  input wire logic cs_b_i,
  input wire logic si_i,
  input wire logic wp_b_i,
  input wire logic pause_b_i,
  output logic so_o,
  output logic so_oe_b_o,
  output logic busy_o
);
  localparam int DEPTH = 1 << ADDR_W;
  localparam int PG = `SEE_PAGE_BYTES;

  ////////////////////////////////////////////////////////////////////////
  // Storage and protect bits (protect bits survive reset, as non-volatile)
  logic [7:0] mem_q [DEPTH];
  logic [1:0] bp_q;
  logic wl_q;
  logic [7:0] page_q [PG];
  logic [PG-1:0] pvalid_q;
  logic [ADDR_W-1:0] page_base_q;
  logic [1:0] pend_bp_q;
  logic pend_is_stat_q;

  ////////////////////////////////////////////////////////////////////////
  // Link side: runs on the serial clock, framed by select
  see_phase_t ph_q, ph_d;
  logic [2:0] bit_q, bit_d;
  logic [7:0] sh_q, sh_d;
  logic [7:0] op_q, op_d;
  logic [ADDR_W-1:0] addr_q, addr_d;
  logic [7:0] tx_q, tx_d;
  logic out_en_q, out_en_d;
  logic [4:0] nbytes_q, nbytes_d;
  logic [3:0] wofs_q, wofs_d;
  logic set_wl_tg_q, set_wl_tg_d;
  logic clr_wl_tg_q, clr_wl_tg_d;
  logic busy_lk1_q, busy_lk2_q;
  logic [7:0] rx_byte;
  logic [7:0] status_lk;
  logic paused;
  logic [7:0] so_q;

  // Busy crosses into link domain as a level
  always_ff @(posedge spi_clk_i) begin
    busy_lk1_q <= busy_o;
    busy_lk2_q <= busy_lk1_q;
  end

  assign paused = !pause_b_i;
  assign rx_byte = {sh_q[6:0], si_i};
  assign status_lk = {`SEE_ST_ONES, bp_q, wl_q, busy_lk2_q};

  always_comb begin
    ph_d = ph_q;
    bit_d = bit_q + 3'd1;
    sh_d = rx_byte;
    op_d = op_q;
    addr_d = addr_q;
    tx_d = tx_q;
    out_en_d = out_en_q;
    nbytes_d = nbytes_q;
    wofs_d = wofs_q;
    set_wl_tg_d = set_wl_tg_q;
    clr_wl_tg_d = clr_wl_tg_q;
    if (paused) begin
      bit_d = bit_q;
      sh_d = sh_q;
    end else if (bit_q == 3'd7) begin
      case (ph_q)
        SEE_PH_OPC: begin
          op_d = rx_byte;
          ph_d = SEE_PH_IDLE;
          if (busy_lk2_q && rx_byte != `SEE_OP_STAT_RD) begin
            ph_d = SEE_PH_IDLE;
          end else if (rx_byte == `SEE_OP_SET_WL) begin
            set_wl_tg_d = !set_wl_tg_q;
          end else if (rx_byte == `SEE_OP_CLR_WL) begin
            clr_wl_tg_d = !clr_wl_tg_q;
          end else if (rx_byte == `SEE_OP_STAT_RD) begin
            ph_d = SEE_PH_STAT;
          end else if (rx_byte == `SEE_OP_STAT_WR) begin
            ph_d = SEE_PH_DATA;
            nbytes_d = 5'd0;
            addr_d = '0;
            wofs_d = 4'd0;
          end else if (rx_byte[7:4] == 4'h0 && rx_byte[2:0] == `SEE_OP_MEM_RD) begin
            ph_d = SEE_PH_ADR;
          end else if (rx_byte[7:4] == 4'h0 && rx_byte[2:0] == `SEE_OP_MEM_WR) begin
            ph_d = SEE_PH_ADR;
          end
        end
        SEE_PH_ADR: begin
          addr_d = ADDR_W'({(ADDR_W > 8) ? op_q[`SEE_OP_A8_BIT] : 1'b0, rx_byte});
          ph_d = SEE_PH_DATA;
          nbytes_d = 5'd0;
          wofs_d = 4'd0;
        end
        SEE_PH_DATA: begin
          if (op_q[2:0] == `SEE_OP_MEM_RD) begin
            addr_d = addr_q + ADDR_W'(1);
          end else if (nbytes_q != 5'd31) begin
            nbytes_d = nbytes_q + 5'd1;
            wofs_d = wofs_q + 4'd1;
          end
        end
        default: ;
      endcase
    end
    if (bit_q == 3'd7 && !paused) begin
      out_en_d = (ph_d == SEE_PH_STAT) || (ph_d == SEE_PH_DATA && op_d[2:0] == `SEE_OP_MEM_RD &&
                 op_d[7:4] == 4'h0 && ph_q != SEE_PH_OPC);
      tx_d = (ph_d == SEE_PH_STAT) ? status_lk : mem_q[addr_d];
    end else if (!paused) begin
      tx_d = {tx_q[6:0], 1'b0};
    end
  end

  // Link state: select high clears it and returns to the opcode phase
  always_ff @(posedge spi_clk_i or posedge cs_b_i) begin
    if (cs_b_i) begin
      ph_q <= SEE_PH_OPC;
      bit_q <= 3'd0;
      sh_q <= 8'h00;
      out_en_q <= 1'b0;
      tx_q <= 8'h00;
    end else begin
      ph_q <= ph_d;
      bit_q <= bit_d;
      sh_q <= sh_d;
      out_en_q <= out_en_d;
      tx_q <= tx_d;
    end
  end

  always_ff @(posedge spi_clk_i) begin
    op_q <= op_d;
    addr_q <= addr_d;
    nbytes_q <= nbytes_d;
    wofs_q <= wofs_d;
    if (!cs_b_i && !paused && bit_q == 3'd7 && ph_q == SEE_PH_DATA && op_q[2:0] != `SEE_OP_MEM_RD) begin
      page_q[addr_q[3:0] + wofs_q] <= rx_byte;
    end
  end

  // Toggles need a known start, or the system side can never see an edge
  always_ff @(posedge spi_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      set_wl_tg_q <= 1'b0;
      clr_wl_tg_q <= 1'b0;
    end else begin
      set_wl_tg_q <= set_wl_tg_d;
      clr_wl_tg_q <= clr_wl_tg_d;
    end
  end

  // Output shifts on falling edge
  always_ff @(negedge spi_clk_i or posedge cs_b_i) begin
    if (cs_b_i) begin
      so_q <= 8'h00;
    end else begin
      so_q <= {out_en_q, 6'h00, tx_q[7]};
    end
  end
  assign so_o = so_q[0];
  assign so_oe_b_o = !(so_q[7] && !cs_b_i && pause_b_i);

  ////////////////////////////////////////////////////////////////////////
  // Frame end: captured on select rising, handed to system clock by toggle
  logic end_tg_q;
  logic valid_wr;
  logic [PG-1:0] mask_wr;
  logic [ADDR_W-1:0] prot_lo;

  always_comb begin
    case (bp_q)
      2'b01: prot_lo = ADDR_W'(DEPTH - DEPTH / 4);
      2'b10: prot_lo = ADDR_W'(DEPTH / 2);
      default: prot_lo = '0;
    endcase
  end

  always_comb begin
    valid_wr = 1'b0;
    mask_wr = '0;
    if (ph_q == SEE_PH_DATA && bit_q == 3'd0 && nbytes_q != 5'd0 && wl_q && wp_b_i && !busy_lk2_q) begin
      if (op_q == `SEE_OP_STAT_WR) begin
        valid_wr = 1'b1;
      end else if (op_q[2:0] == `SEE_OP_MEM_WR && (bp_q == 2'b00 || (bp_q != 2'b11 && addr_q < prot_lo))) begin
        valid_wr = 1'b1;
      end
      for (int i = 0; i < PG; i++) begin
        if (5'(i) < nbytes_q) begin
          mask_wr[4'(addr_q[3:0] + 4'(i))] = 1'b1;
        end
      end
    end
  end

  // Toggle starts known so the system side never sees a false frame end
  always_ff @(posedge cs_b_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      end_tg_q <= 1'b0;
    end else if (valid_wr) begin
      end_tg_q <= !end_tg_q;
    end
  end

  always_ff @(posedge cs_b_i) begin
    if (valid_wr) begin
      pvalid_q <= mask_wr;
      page_base_q <= {addr_q[ADDR_W-1:4], 4'h0};
      pend_bp_q <= page_q[0][3:2];
      pend_is_stat_q <= (op_q == `SEE_OP_STAT_WR);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // System side: programming timer, latch and commit
  logic [2:0] end_s_q, set_s_q, clr_s_q;
  logic busy_q, busy_d, wl_d;
  logic [31:0] cnt_q, cnt_d;
  logic commit;

  always_ff @(posedge clk_sys_i) begin
    end_s_q <= {end_s_q[1:0], end_tg_q};
    set_s_q <= {set_s_q[1:0], set_wl_tg_q};
    clr_s_q <= {clr_s_q[1:0], clr_wl_tg_q};
  end

  always_comb begin
    busy_d = busy_q;
    cnt_d = cnt_q;
    wl_d = wl_q;
    commit = 1'b0;
    if (set_s_q[2] != set_s_q[1]) wl_d = 1'b1;
    if (clr_s_q[2] != clr_s_q[1]) wl_d = 1'b0;
    if (busy_q) begin
      if (cnt_q == PROG_CYCLES - 1) begin
        busy_d = 1'b0;
        commit = 1'b1;
        wl_d = 1'b0;
      end else begin
        cnt_d = cnt_q + 32'd1;
      end
    end else if (end_s_q[2] != end_s_q[1]) begin
      busy_d = 1'b1;
      cnt_d = 32'd0;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      busy_q <= 1'b0;
      wl_q <= 1'b0;
      cnt_q <= 32'd0;
    end else begin
      busy_q <= busy_d;
      wl_q <= wl_d;
      cnt_q <= cnt_d;
    end
  end

  // Commit stays on the system clock; link reads of the array are blocked while busy
  always_ff @(posedge clk_sys_i) begin
    if (commit) begin
      if (pend_is_stat_q) begin
        bp_q <= pend_bp_q;
      end else begin
        for (int i = 0; i < PG; i++) begin
          if (pvalid_q[i]) mem_q[page_base_q | ADDR_W'(i)] <= page_q[i];
        end
      end
    end
  end

  assign busy_o = busy_q;
endmodule // see_core

/* see_host.sv */
// SPI host model in modes 0 and 3 for the serial EEPROM core
`timescale 1ns/10ps
module see_host (
  output logic spi_clk_o,
  output logic cs_b_o,
  output logic si_o,
  output logic pause_b_o,
  input wire logic so_i,
  input wire logic so_oe_b_i
);
  logic idle_hi = 1'b0;
  int pause_at = -1;
  initial begin
    spi_clk_o = 1'b0;
    cs_b_o = 1'b1;
    si_o = 1'b0;
    pause_b_o = 1'b1;
  end
  // Clock runs only inside frames; odd start offset keeps it off the system clock phase
  task automatic frame(input logic [7:0] tx[$], output logic [7:0] rx[$], output logic drove);
    logic [7:0] b;
    rx = {};
    drove = 1'b0;
    spi_clk_o = idle_hi;
    #16.3 cs_b_o = 1'b0;
    #8;
    foreach (tx[i]) begin
      for (int k = 7; k >= 0; k--) begin
        spi_clk_o = 1'b0;
        if (pause_at == i * 8 + 7 - k) begin
          // A clock pulse and data noise while paused must both be ignored
          #8 pause_b_o = 1'b0;
          si_o = ~si_o;
          #8 spi_clk_o = 1'b1;
          #8 spi_clk_o = 1'b0;
          #8 pause_b_o = 1'b1;
          #8;
        end
        si_o = tx[i][k];
        #16 spi_clk_o = 1'b1;
        // An undriven output line reads inverted, so a lost enable shows up
        b[k] = so_oe_b_i ? !so_i : so_i;
        drove |= !so_oe_b_i;
        #16;
      end
      rx.push_back(b);
    end
    spi_clk_o = idle_hi;
    #16 cs_b_o = 1'b1;
    pause_at = -1;
    // Released data line must not keep looking valid
    si_o = ~si_o;
    #48;
  endtask
endmodule // see_host

/* see_core_checker.sv */
// Assertions on the serial EEPROM core ports
`timescale 1ns/10ps
module see_core_checker #(
  parameter int unsigned PROG_CYCLES = 50
) (
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  input wire logic spi_clk_i,
  input wire logic cs_b_i,
  input wire logic si_i,
  input wire logic wp_b_i,
  input wire logic pause_b_i,
  input wire logic so_o,
  input wire logic so_oe_b_o,
  input wire logic busy_o
);
  logic [5:0] bits_q;
  int unsigned busy_q;
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_b_i);
  // Select clears the bit count, since the link clock stops between frames
  always_ff @(posedge spi_clk_i or posedge cs_b_i) begin
    if (cs_b_i) begin
      bits_q <= 6'h00;
    end else if (bits_q != 6'h3F) begin
      bits_q <= bits_q + 6'h01;
    end
  end
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i || !busy_o) begin
      busy_q <= 0;
    end else begin
      busy_q <= busy_q + 1;
    end
  end
  a_idle_hiz: assert property (cs_b_i && $past(cs_b_i) |-> so_oe_b_o) else $error("so driven");
  a_so_edge: assert property (!so_oe_b_o && $changed(so_o) |-> !spi_clk_i) else $error("so moved");
  a_op_first: assert property (!so_oe_b_o && !cs_b_i |-> bits_q >= 6'h08) else $error("early so");
  a_busy_wp: assert property ($rose(busy_o) |-> wp_b_i) else $error("busy with wp");
  a_busy_cs: assert property ($rose(busy_o) |-> cs_b_i) else $error("busy in frame");
  a_busy_hold: assert property ($rose(busy_o) |-> busy_o [*8]) else $error("busy short");
  a_busy_len: assert property ($fell(busy_o) |-> busy_q inside {[PROG_CYCLES:PROG_CYCLES + 1]})
    else $error("busy len");
  a_reset_idle: assert property ($rose(rst_b_i) |-> !busy_o) else $error("busy at reset");
  c_prog: cover property ($fell(busy_o));
  c_read: cover property (!so_oe_b_o && !cs_b_i);
  c_frame: cover property ($rose(cs_b_i));
endmodule // see_core_checker

bind see_core see_core_checker #(.PROG_CYCLES(PROG_CYCLES)) see_core_checker_i (.clk_sys_i(clk_sys_i),
  .rst_b_i(rst_b_i), .spi_clk_i(spi_clk_i), .cs_b_i(cs_b_i), .si_i(si_i), .wp_b_i(wp_b_i),
  .pause_b_i(pause_b_i), .so_o(so_o), .so_oe_b_o(so_oe_b_o), .busy_o(busy_o));

/* see_core_bench.sv */
// Self-checking bench for the serial EEPROM core
`timescale 1ns/10ps
module see_core_bench;
  import see_pkg::*;
  localparam int PROG = 400;
  localparam int PWR_UP_CYC = 25000;
  logic clk_sys_i = 1'b0;
  logic rst_b_i = 1'b1;
  logic wp_b_i = 1'b1;
  logic spi_clk, cs_b, si, pause_b, so, so_oe_b, busy, drove;
  logic [7:0] rx[$];
  int failures = 0;
  int checked = 0;
  always #2 clk_sys_i = ~clk_sys_i;
  see_core #(.PROG_CYCLES(PROG)) see_core_i (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .spi_clk_i(spi_clk),
    .cs_b_i(cs_b), .si_i(si), .wp_b_i(wp_b_i), .pause_b_i(pause_b), .so_o(so), .so_oe_b_o(so_oe_b), .busy_o(busy));
  see_host see_host_i (.spi_clk_o(spi_clk), .cs_b_o(cs_b), .si_o(si), .pause_b_o(pause_b), .so_i(so),
    .so_oe_b_i(so_oe_b));
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic test_done();
    if (failures == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic xfer(input logic [7:0] tx[$]);
    see_host_i.frame(tx, rx, drove);
  endtask
  task automatic stat(input logic [7:0] msk, input logic [7:0] exp);
    xfer('{8'h05, 8'h00});
    chk("status", rx[1] & msk, exp);
  endtask
  // Busy is only polled after the hand-over settling time
  task automatic prog();
    repeat (8) @(negedge clk_sys_i);
    chk("busy", {7'h00, busy}, 8'h01);
    xfer('{8'h04});
    stat(8'h03, 8'h03);
    for (int i = 0; i < 1000 && busy === 1'b1; i++) @(negedge clk_sys_i);
    stat(8'h03, 8'h00);
  endtask
  task automatic wr(input logic [7:0] tx[$], input logic go);
    xfer('{8'h06});
    xfer(tx);
    if (go) begin
      prog();
    end else begin
      repeat (8) @(negedge clk_sys_i);
      chk("busy", {7'h00, busy}, 8'h00);
    end
  endtask
  initial begin
    #300000;
    failures++;
    test_done();
  end
  initial begin
    #1 rst_b_i = 1'b0;
    repeat (3) @(negedge clk_sys_i);
    rst_b_i = 1'b1;
    repeat (2) @(negedge clk_sys_i);
    repeat (PWR_UP_CYC) @(negedge clk_sys_i);
    stat(8'hF3, 8'hF0);
    xfer('{8'h01, 8'hFF});
    repeat (8) @(negedge clk_sys_i);
    chk("busy", {7'h00, busy}, 8'h00);
    xfer('{8'h06});
    stat(8'hF3, 8'hF2);
    xfer('{8'h04});
    stat(8'hF3, 8'hF0);
    wr('{8'h01, 8'hFF}, 1'b1);
    stat(8'hFF, 8'hFC);
    wr('{8'h02, 8'h10, 8'hAA}, 1'b0);
    wr('{8'h01, 8'h04}, 1'b1);
    stat(8'hFF, 8'hF4);
    wr('{8'h0A, 8'h80, 8'h11}, 1'b0);
    wr('{8'h0A, 8'h7F, 8'h5A}, 1'b1);
    @(negedge clk_sys_i);
    wp_b_i = 1'b0;
    wr('{8'h01, 8'h00}, 1'b0);
    @(negedge clk_sys_i);
    wp_b_i = 1'b1;
    wr('{8'h01, 8'h00}, 1'b1);
    wr('{8'h0A, 8'hFF, 8'hA1, 8'hB2}, 1'b1);
    wr('{8'h02, 8'h00, 8'hC3}, 1'b1);
    see_host_i.pause_at = 20;
    xfer('{8'h0B, 8'hFF, 8'h00, 8'h00});
    chk("rd_top", rx[2], 8'hA1);
    chk("rd_wrap", rx[3], 8'hC3);
    see_host_i.idle_hi = 1'b1;
    xfer('{8'h0B, 8'hF0, 8'h00});
    chk("rd_page", rx[2], 8'hB2);
    xfer('{8'h0B, 8'h7F, 8'h00});
    chk("rd_a8", rx[2], 8'h5A);
    see_host_i.idle_hi = 1'b0;
    xfer('{8'h03, 8'h00, 8'h00});
    chk("rd_low", rx[2], 8'hC3);
    xfer('{8'hFF, 8'h00});
    chk("drove", {7'h00, drove}, 8'h00);
    test_done();
  end
endmodule // see_core_bench
